// File: pkg/ppm_pkg.sv
// shared constants and types of the port pin function mux
package ppm_pkg;
   // ==========================================================
   // geometry
   localparam int PPM_PORTS = 6;
   localparam int PPM_W = 8;
   localparam int PPM_PINS = 48;
   localparam int PPM_ALT_PINS = 32;
   localparam int PPM_DMA_CH = 4;
   localparam int PPM_DRQ_BIT0 = 4;
   localparam int PPM_DAK_BIT0 = 12;
   localparam int PPM_NMI_PIN = 16;
   localparam int PPM_P21_PIN = 17;
   localparam int PPM_DBUS_LO = 32;
   localparam int PPM_DBUS_HI = 47;
   // ==========================================================
   // encodings and reset values
   localparam logic PPM_DIR_IN = 1'b1;
   localparam logic [7:0] PPM_DIR_RST = 8'hFF;
   localparam logic [7:0] PPM_P2_ALT_MASK = 8'hFC;
   localparam logic [3:0] PPM_MODE_SINGLE = 4'h0;
   localparam logic [15:0] PPM_DBUS_RST = 16'h0000;
   localparam logic [3:0] PPM_ACK_RST = 4'h0;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      PPM_BUS_IDLE = 2'h0,
      PPM_BUS_FIRST = 2'h1,
      PPM_BUS_DATA = 2'h3
   } ppm_bus_e;
   typedef enum logic [2:0] {
      PPM_DMA_NONE = 3'h0,
      PPM_DMA_FIRST = 3'h1,
      PPM_DMA_RD_START = 3'h3,
      PPM_DMA_FLY_START = 3'h2,
      PPM_DMA_XFER = 3'h6
   } ppm_dma_e;
   typedef struct packed {
      ppm_bus_e state;
      logic write;
      logic [15:0] wdata;
   } ppm_bus_s;
   typedef struct packed {
      ppm_dma_e state;
      logic [1:0] chan;
      logic external;
   } ppm_dma_s;
   typedef struct packed {
      logic [5:0][7:0] dir;
      logic [3:0][7:0] fsel;
      logic mem_exp;
   } ppm_cfg_s;
endpackage

// File: hw/ppm_pin_mux.sv
// pin function multiplexer for ports 0 to 5 with dma and data bus pin logic
// How it works
// RULE1 - each pin of ports 0..5 has its own direction bit in port mode
// RULE2 - ports 0, 1, 3 pick port or alternate function per bit
// RULE3 - port 2 pins 2..7 may switch; pin 1 stays port with direction
// RULE4 - port 2 pin 0 is input only; a valid edge raises nmi
// RULE5 - ports 4, 5 become data bus from mode pins or expansion select
// RULE6 - expansion mode: port 4 low byte, port 5 high byte, both ways
// RULE7 - driven data changes on system clock fall in bus first state
// RULE8 - data bus pins float during bus idle state
// RULE9 - four dma requests map to channels 0..3, channel 0 wins
// RULE10 - dma requests are sampled on system clock falling edge
// RULE11 - requester holds request active until the device accepts it
// RULE12 - each acknowledge marks its channel, only for external memory access
// RULE13 - acknowledges stay inactive for internal-only dma transfers
// RULE14 - acknowledge rises at fall in dma start states, held through transfer
// RULE15 - selected alternate function owns pin drive and direction
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_mux
   import ppm_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire ppm_cfg_s cfg_i,
   input wire logic [3:0] operating_mode_pins_i,
   input wire logic [PPM_PINS-1:0] port_out_i,
   input wire logic [PPM_ALT_PINS-1:0] alt_out_i,
   input wire logic [PPM_ALT_PINS-1:0] alt_drive_i,
   input wire ppm_bus_s bus_i,
   input wire ppm_dma_s dma_i,
   input wire logic nmi_rise_en_i,
   input wire logic nmi_fall_en_i,
   input wire logic [PPM_PINS-1:0] pin_i,
   output logic [PPM_PINS-1:0] pin_o,
   output logic [PPM_PINS-1:0] pin_oe_n_o,
   output logic [PPM_PINS-1:0] port_in_o,
   output logic [15:0] bus_rdata_o,
   output logic ext_mode_o,
   output logic system_clock_output_o,
   output logic nmi_req_o,
   output logic [PPM_DMA_CH-1:0] dma_req_o,
   output logic [PPM_DMA_CH-1:0] dma_grant_o,
   output logic [PPM_DMA_CH-1:0] dma_ack_o
);
   // ==========================================================
   // pin synchronisers
   logic [PPM_PINS-1:0] pin_s1_ff;
   logic [PPM_PINS-1:0] pin_s2_ff;
   logic [3:0] mode_s1_ff;
   logic [3:0] mode_s2_ff;
   // two stages: the first stage feeds only the second
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         mode_s1_ff <= PPM_MODE_SINGLE;
         mode_s2_ff <= PPM_MODE_SINGLE;
      end
      else if (clk_en_i)
      begin
         pin_s1_ff <= pin_i;
         pin_s2_ff <= pin_s1_ff;
         mode_s1_ff <= operating_mode_pins_i;
         mode_s2_ff <= mode_s1_ff;
      end
   end
   assign port_in_o = pin_s2_ff;
   assign bus_rdata_o = pin_s2_ff[PPM_DBUS_HI:PPM_DBUS_LO]; // RULE6
   // ==========================================================
   // system clock output, half the core rate
   logic system_clock_output_ff;
   logic clk_fall;
   // a fall is the enabled cycle in which the output goes from high to low
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         system_clock_output_ff <= 1'b0;
      else if (clk_en_i)
         system_clock_output_ff <= ~system_clock_output_ff;
   end
   assign clk_fall = system_clock_output_ff & clk_en_i;
   assign system_clock_output_o = system_clock_output_ff;
   // ==========================================================
   // expansion mode select
   logic ext_mode_ff;
   // mode pins leaving single-chip, or software expansion, claim ports 4 and 5
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ext_mode_ff <= 1'b0;
      else if (clk_en_i)
         ext_mode_ff <= (mode_s2_ff != PPM_MODE_SINGLE) | cfg_i.mem_exp; // RULE5
   end
   assign ext_mode_o = ext_mode_ff;
   // ==========================================================
   // external data bus drive
   logic [15:0] bus_data_ff;
   logic bus_drive_ff;
   // data only moves at the fall in the first state; idle releases at once
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bus_data_ff <= PPM_DBUS_RST;
         bus_drive_ff <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (bus_i.state == PPM_BUS_IDLE)
            bus_drive_ff <= 1'b0; // RULE8
         else if (clk_fall && bus_i.state == PPM_BUS_FIRST)
         begin
            bus_data_ff <= bus_i.wdata; // RULE7
            bus_drive_ff <= bus_i.write; // RULE6
         end
      end
   end
   // ==========================================================
   // nmi edge detect on port 2 pin 0
   logic nmi_prev_ff;
   logic nmi_ff;
   // edge seen on the synchronised level, never on the first stage
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         nmi_prev_ff <= 1'b0;
         nmi_ff <= 1'b0;
      end
      else if (clk_en_i)
      begin
         nmi_prev_ff <= pin_s2_ff[PPM_NMI_PIN];
         nmi_ff <= (nmi_rise_en_i & pin_s2_ff[PPM_NMI_PIN] & ~nmi_prev_ff)
                 | (nmi_fall_en_i & ~pin_s2_ff[PPM_NMI_PIN] & nmi_prev_ff); // RULE4
      end
   end
   assign nmi_req_o = nmi_ff;
   // ==========================================================
   // dma requests, active low pins on port 0 bits 4..7
   logic [PPM_DMA_CH-1:0] drq_ff;
   logic [PPM_DMA_CH-1:0] grant_ff;
   logic [PPM_DMA_CH-1:0] nxt_drq;
   logic [PPM_DMA_CH-1:0] nxt_grant;
   // fixed priority: the lowest channel number wins
   always_comb
   begin
      nxt_grant = '0;
      for (int c = 0; c < PPM_DMA_CH; c++)
         nxt_drq[c] = ~pin_s2_ff[PPM_DRQ_BIT0+c] & cfg_i.fsel[0][PPM_DRQ_BIT0+c]; // RULE9
      for (int c = PPM_DMA_CH - 1; c >= 0; c--)
         if (nxt_drq[c])
            nxt_grant = PPM_DMA_CH'(1) << c; // RULE9
   end
   // the requester keeps its level until accepted, so sampling only at falls loses nothing
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         drq_ff <= '0;
         grant_ff <= '0;
      end
      else if (clk_fall)
      begin
         drq_ff <= nxt_drq; // RULE10 RULE11
         grant_ff <= nxt_grant;
      end
   end
   assign dma_req_o = drq_ff;
   assign dma_grant_o = grant_ff;
   // ==========================================================
   // dma acknowledges, active low pins on port 1 bits 4..7
   logic [PPM_DMA_CH-1:0] ack_ff;
   logic dma_start;
   assign dma_start = (dma_i.state == PPM_DMA_FIRST) || (dma_i.state == PPM_DMA_RD_START)
                    || (dma_i.state == PPM_DMA_FLY_START);
   // internal-only transfers or the end of a transfer drop the acknowledge at once
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ack_ff <= PPM_ACK_RST;
      else if (clk_en_i)
      begin
         if (!dma_i.external || dma_i.state == PPM_DMA_NONE)
            ack_ff <= PPM_ACK_RST; // RULE13
         else if (clk_fall && dma_start)
            ack_ff <= PPM_DMA_CH'(1) << dma_i.chan; // RULE12 RULE14
      end
   end
   assign dma_ack_o = ack_ff;
   // ==========================================================
   // pin drive selection
   logic [PPM_PINS-1:0] pin_ff;
   logic [PPM_PINS-1:0] oe_n_ff;
   logic [PPM_PINS-1:0] nxt_pin;
   logic [PPM_PINS-1:0] nxt_oe_n;
   // port latch by default; alternate, bus or acknowledge override it
   always_comb
   begin
      nxt_pin = port_out_i;
      nxt_oe_n = {cfg_i.dir[5], cfg_i.dir[4], cfg_i.dir[3], cfg_i.dir[2], cfg_i.dir[1], cfg_i.dir[0]}; // RULE1
      for (int i = 0; i < PPM_ALT_PINS; i++)
      begin
         if (cfg_i.fsel[i/PPM_W][i%PPM_W] && (i/PPM_W != 2 || PPM_P2_ALT_MASK[i%PPM_W])) // RULE2 RULE3
         begin
            nxt_pin[i] = alt_out_i[i]; // RULE15
            nxt_oe_n[i] = ~alt_drive_i[i]; // RULE15
         end
      end
      for (int c = 0; c < PPM_DMA_CH; c++)
      begin
         if (cfg_i.fsel[1][PPM_DAK_BIT0-PPM_W+c])
         begin
            nxt_pin[PPM_DAK_BIT0+c] = ~ack_ff[c]; // RULE12
            nxt_oe_n[PPM_DAK_BIT0+c] = 1'b0;
         end
      end
      nxt_pin[PPM_NMI_PIN] = 1'b0;
      nxt_oe_n[PPM_NMI_PIN] = 1'b1; // RULE4
      if (ext_mode_ff)
      begin
         nxt_pin[PPM_DBUS_HI:PPM_DBUS_LO] = bus_data_ff; // RULE6
         nxt_oe_n[PPM_DBUS_HI:PPM_DBUS_LO] = {16{~bus_drive_ff}}; // RULE8
      end
   end
   // registered so every pin leaves a flip-flop; costs one cycle of latency
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_ff <= '0;
         oe_n_ff <= '1;
      end
      else if (clk_en_i)
      begin
         pin_ff <= nxt_pin;
         oe_n_ff <= nxt_oe_n;
      end
   end
   assign pin_o = pin_ff;
   assign pin_oe_n_o = oe_n_ff;
   // ==========================================================
   // checks
   // the first edge after reset is skipped: $past still sees the inputs of the reset time
   a_port4_dir: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE1
      $past(rst_n_i) && $past(clk_en_i) && !$past(ext_mode_ff) |-> pin_oe_n_o[39:32] == $past(cfg_i.dir[4]))
      else $error("port 4 direction not followed");
   a_port1_dir: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE1
      $past(rst_n_i) && $past(clk_en_i) && !$past(cfg_i.fsel[1][0]) |-> pin_oe_n_o[8] == $past(cfg_i.dir[1][0]))
      else $error("port 1 direction not followed");
   a_fsel_owns_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE2
      $past(rst_n_i) && $past(clk_en_i) && $past(cfg_i.fsel[3][0]) |->
         pin_o[24] == $past(alt_out_i[24]) && pin_oe_n_o[24] == !$past(alt_drive_i[24]))
      else $error("alternate function not owning port 3 pin 0");
   a_p21_port_only: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE3
      $past(rst_n_i) && $past(clk_en_i) |-> pin_oe_n_o[PPM_P21_PIN] == $past(cfg_i.dir[2][1])
         && pin_o[PPM_P21_PIN] == $past(port_out_i[PPM_P21_PIN]))
      else $error("port 2 pin 1 left port mode");
   a_nmi_input_only: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE4
      pin_oe_n_o[PPM_NMI_PIN] && (!nmi_req_o || $past(nmi_rise_en_i || nmi_fall_en_i)))
      else $error("nmi pin driven or spurious nmi");
   a_mode_selects_bus: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE5
      $past(rst_n_i) && $past(clk_en_i) |->
         ext_mode_o == ($past(cfg_i.mem_exp) || $past(mode_s2_ff) != PPM_MODE_SINGLE))
      else $error("expansion mode not from mode pins and select");
   a_bus_owns_ports: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE6
      $past(clk_en_i) && $past(ext_mode_ff) && $past(bus_drive_ff) |->
         pin_o[PPM_DBUS_HI:PPM_DBUS_LO] == $past(bus_data_ff) && pin_oe_n_o[PPM_DBUS_HI:PPM_DBUS_LO] == 16'h0000)
      else $error("data bus not on ports 4 and 5");
   a_bus_change_t1: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE7
      bus_data_ff != $past(bus_data_ff) |-> $past(clk_fall) && $past(bus_i.state) == PPM_BUS_FIRST)
      else $error("data bus changed outside first state fall");
   a_bus_idle_float: assert property (@(posedge clock_i) disable iff (!rst_n_i || !clk_en_i) // RULE8
      bus_i.state == PPM_BUS_IDLE && ext_mode_ff ##1 clk_en_i && ext_mode_ff |=> &pin_oe_n_o[PPM_DBUS_HI:PPM_DBUS_LO])
      else $error("data bus driven in idle");
   a_dma_priority: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE9
      dma_grant_o == (dma_req_o & (~dma_req_o + 4'h1)))
      else $error("dma grant not lowest channel");
   a_drq_on_fall: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE10
      dma_req_o != $past(dma_req_o) |-> $past(clk_fall))
      else $error("dma request sampled off the fall");
   a_ack_internal: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE13
      clk_en_i && !dma_i.external |=> dma_ack_o == 4'h0)
      else $error("acknowledge on internal transfer");
   a_ack_start: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE14
      clk_fall && dma_start && dma_i.external |=> dma_ack_o == (4'h1 << $past(dma_i.chan)))
      else $error("acknowledge missing at dma start");
   a_ack_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE14
      clk_en_i && dma_i.external && dma_i.state == PPM_DMA_XFER |=> $stable(dma_ack_o))
      else $error("acknowledge not held through transfer");
   a_ack_pin_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE12
      $past(rst_n_i) && $past(clk_en_i) && $past(cfg_i.fsel[1][4]) |->
         !pin_oe_n_o[PPM_DAK_BIT0] && pin_o[PPM_DAK_BIT0] == !$past(dma_ack_o[0]))
      else $error("acknowledge pin of channel 0 not driven");
   a_alt_owns_port0: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RULE15
      $past(rst_n_i) && $past(clk_en_i) && $past(cfg_i.fsel[0][0]) |->
         pin_o[0] == $past(alt_out_i[0]) && pin_oe_n_o[0] == !$past(alt_drive_i[0]))
      else $error("port latch leaked onto alternate pin");
endmodule
`default_nettype wire

// File: tb/ppm_far_side.sv
// far-side model of the pins: dma requesters, external memory and nmi source
`timescale 1ns/1ps
`default_nettype none
module ppm_far_side
   import ppm_pkg::*;
(
   input wire logic clock_i,
   input wire logic [PPM_PINS-1:0] dev_pin_i,
   input wire logic [PPM_PINS-1:0] dev_oe_n_i,
   input wire logic [3:0] req_set_i,
   input wire logic rd_en_i,
   input wire logic [15:0] rd_data_i,
   input wire logic nmi_lvl_i,
   output logic [PPM_PINS-1:0] pin_lvl_o
);
   logic [3:0] pend_ff = 4'h0;
   logic [PPM_PINS-1:0] far_ff = '0;
   logic [PPM_PINS-1:0] far;
   // ==========================================================
   // requesters
   // a request stays pending until the device pulls that channel's ack pin low
   always_ff @(posedge clock_i)
   begin
      for (int c = 0; c < 4; c++)
      begin
         if (req_set_i[c])
            pend_ff[c] <= 1'b1;
         else if (!dev_oe_n_i[PPM_DAK_BIT0+c] && !dev_pin_i[PPM_DAK_BIT0+c])
            pend_ff[c] <= 1'b0;
      end
      far_ff <= ~pin_lvl_o; // floating pins with no far-side driver never keep their last level
   end
   // ==========================================================
   // wire resolution
   // the device wins wherever it drives; request pins idle high as if pulled up
   always_comb
   begin
      far = far_ff;
      far[PPM_DRQ_BIT0 +: 4] = ~pend_ff;
      far[PPM_NMI_PIN] = nmi_lvl_i;
      if (rd_en_i)
         far[PPM_DBUS_HI:PPM_DBUS_LO] = rd_data_i;
      for (int i = 0; i < PPM_PINS; i++)
         pin_lvl_o[i] = dev_oe_n_i[i] ? far[i] : dev_pin_i[i];
   end
endmodule
`default_nettype wire

// File: tb/port_pin_function_mux_bench.sv
// self-checking bench for the port pin function mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
$display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end
module port_pin_function_mux_bench;
   import ppm_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   ppm_cfg_s cfg = '{dir: {6{8'hFF}}, fsel: '0, mem_exp: 1'b0};
   logic [3:0] mode = 4'h0;
   logic [PPM_PINS-1:0] pout = '0;
   logic [31:0] alt_out = '0;
   logic [31:0] alt_drv = '0;
   ppm_bus_s bus = '{PPM_BUS_IDLE, 1'b0, 16'h0000};
   ppm_dma_s dma = '{PPM_DMA_NONE, 2'h0, 1'b0};
   logic nmi_r = 1'b0;
   logic nmi_f = 1'b0;
   logic nmi_lvl = 1'b0;
   logic clk_en = 1'b1;
   logic rd_en = 1'b0;
   logic [15:0] rd_data = 16'h0000;
   logic [3:0] req_set = 4'h0;
   logic [PPM_PINS-1:0] pin_i, pin_o, oe_n, port_in, exp_oe, exp_val;
   logic [15:0] rdata;
   logic ext, clko, nmi;
   logic [3:0] dreq, dgnt, dack;
   logic [31:0] alt_sel;
   logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h8, 4'h0};
   ppm_dma_e starts [3] = '{PPM_DMA_FIRST, PPM_DMA_RD_START, PPM_DMA_FLY_START};
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int nmi_cnt = 0;
   // ==========================================================
   // clock, watchdog and nmi pulse counter
   always #5 clock_i = ~clock_i;
   // the whole run needs well under a thousand cycles
   always @(posedge clock_i)
   begin
      cyc++;
      if (nmi === 1'b1)
         nmi_cnt++;
      if (cyc == 3000)
      begin
         fail_count++;
         finish_test;
      end
   end
   // ==========================================================
   // instances
   ppm_pin_mux DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .cfg_i(cfg),
      .operating_mode_pins_i(mode), .port_out_i(pout), .alt_out_i(alt_out), .alt_drive_i(alt_drv),
      .bus_i(bus), .dma_i(dma), .nmi_rise_en_i(nmi_r), .nmi_fall_en_i(nmi_f), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_n_o(oe_n), .port_in_o(port_in), .bus_rdata_o(rdata), .ext_mode_o(ext),
      .system_clock_output_o(clko), .nmi_req_o(nmi), .dma_req_o(dreq), .dma_grant_o(dgnt),
      .dma_ack_o(dack));
   ppm_far_side FAR (.clock_i(clock_i), .dev_pin_i(pin_o), .dev_oe_n_i(oe_n), .req_set_i(req_set),
      .rd_en_i(rd_en), .rd_data_i(rd_data), .nmi_lvl_i(nmi_lvl), .pin_lvl_o(pin_i));
   // ==========================================================
   // access tasks
   // inputs always move 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // stop in the cycle whose closing edge is a system clock fall
   task automatic wait_fall;
      int n;
      n = 0;
      while (clko !== 1'b1 && n < 4)
      begin
         tick(1);
         n++;
      end
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================================
   // test sequence
   initial
   begin
      tick(8);
      `CHK("oe_rst", {PPM_PINS{1'b1}}, oe_n)
      rst_n_i = 1'b1;
      // mixed directions per bit; the nmi pin must stay undriven
      cfg.dir = 48'h0F33_00A5_C300;
      pout = 48'hA5C3_96F0_3C5A;
      tick(2);
      exp_oe = cfg.dir | (48'h1 << PPM_NMI_PIN);
      `CHK("port_oe", exp_oe, oe_n)
      `CHK("port_val", pout & ~exp_oe, pin_o & ~exp_oe)
      // driven levels come back through the two synchroniser stages
      tick(2);
      `CHK("port_in", pout & ~exp_oe, port_in & ~exp_oe)
      // alternate functions own drive and value; port 2 pins 0 and 1 stay port pins
      cfg.dir = '0;
      cfg.fsel = 32'hFFFF_0F0F;
      alt_out = 32'h5A3C_C35A;
      alt_drv = 32'hF0F0_FF0F;
      tick(2);
      alt_sel = cfg.fsel & ~32'h0003_0000;
      exp_oe = {16'h0000, (alt_sel & ~alt_drv) | 32'h0001_0000};
      exp_val = {pout[47:32], (alt_sel & alt_out) | (~alt_sel & pout[31:0])};
      `CHK("alt_oe", exp_oe, oe_n)
      `CHK("alt_val", exp_val & ~exp_oe, pin_o & ~exp_oe)
      // expansion mode: data bus floats when idle whatever the direction bits say
      cfg.mem_exp = 1'b1;
      tick(3);
      `CHK("ext", 1'b1, ext)
      `CHK("bus_idle", 16'hFFFF, oe_n[47:32])
      wait_fall;
      bus = '{PPM_BUS_FIRST, 1'b1, 16'hC35A};
      tick(1);
      bus.state = PPM_BUS_DATA;
      `CHK("wr_early", 16'hFFFF, oe_n[47:32])
      tick(1);
      `CHK("wr_oe", 16'h0000, oe_n[47:32])
      `CHK("wr_data", 16'hC35A, pin_o[47:32])
      bus.state = PPM_BUS_IDLE;
      tick(2);
      `CHK("wr_idle", 16'hFFFF, oe_n[47:32])
      wait_fall;
      bus = '{PPM_BUS_FIRST, 1'b0, 16'h0000};
      rd_data = 16'h96E1;
      rd_en = 1'b1;
      tick(1);
      bus.state = PPM_BUS_DATA;
      tick(3);
      `CHK("rd_data", 16'h96E1, rdata)
      bus.state = PPM_BUS_IDLE;
      rd_en = 1'b0;
      // mode pins alone select expansion; code 0 is single chip
      cfg.mem_exp = 1'b0;
      foreach (codes[k])
      begin
         mode = codes[k];
         tick(5);
         `CHK("mode", codes[k] != 4'h0, ext)
      end
      // nmi edges: rising only, then falling only
      for (int k = 0; k < 4; k++)
      begin
         nmi_r = (k < 2);
         nmi_f = (k >= 2);
         nmi_lvl = ~k[0];
         tick(6);
         `CHK("nmi", (k == 3) ? 2 : 1, nmi_cnt)
      end
      // requests on channels 1 and 3; channel 1 must win
      cfg.fsel[0] = 8'hF0;
      cfg.fsel[1] = 8'hF0;
      alt_drv = '0;
      req_set = 4'hA;
      tick(1);
      req_set = 4'h0;
      tick(8);
      `CHK("dreq", 4'hA, dreq)
      `CHK("grant", 4'h2, dgnt)
      for (int k = 0; k < 3; k++)
      begin
         wait_fall;
         dma = '{starts[k], 2'(k), 1'b1};
         tick(1);
         dma.state = PPM_DMA_XFER;
         tick(5);
         `CHK("ack", 4'h1 << k, dack)
         `CHK("ack_pin", 1'b0, pin_o[PPM_DAK_BIT0+k] | oe_n[PPM_DAK_BIT0+k])
         dma.state = PPM_DMA_NONE;
         tick(2);
         `CHK("ack_off", 4'h0, dack)
      end
      // internal-only transfer: no acknowledge at all
      wait_fall;
      dma = '{PPM_DMA_FIRST, 2'h3, 1'b0};
      tick(4);
      `CHK("ack_int", 4'h0, dack)
      `CHK("grant3", 4'h8, dgnt)
      // clock enable low freezes every flop, the clock output included
      clk_en = 1'b0;
      exp_val[0] = clko;
      cfg.dir[1] = 8'h0F;
      tick(3);
      `CHK("frz_clk", exp_val[0], clko)
      `CHK("frz_oe", 4'h0, oe_n[11:8])
      clk_en = 1'b1;
      tick(1);
      `CHK("run_clk", ~exp_val[0], clko)
      `CHK("run_oe", 4'hF, oe_n[11:8])
      finish_test;
   end
endmodule
`default_nettype wire
